// >>> plg_gateway.sv
// module: ladderless gateway handshake, health flags and group commands
`timescale 1ns/1ps
`default_nettype none
module plg_gateway #(
  parameter int SEC_CYCLES = plg_pkg::CLK_HZ,
  parameter logic [7:0] START_DELAY_S = 8'(plg_pkg::START_DELAY_DEFAULT_S)
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // module gathering and link activity (pins, synchronised here except chained_units)
  input wire logic gather_done,
  input wire logic [4:0] module_count,
  input wire logic [3:0] unit_present,
  input wire logic sys_activity,
  input wire logic addr_seq_ok,
  input wire logic internal_err,
  input wire logic master_link_err,
  input wire logic slave_mode,
  input wire logic master_sending,
  input wire logic [1:0] chained_units,
  // controller register port
  input wire logic [7:0] start_delay_s,
  input wire logic req_wr_set,
  input wire logic req_rd_set,
  input wire logic period_tick,
  // transfer engine
  output logic xfer_wr_start,
  output logic xfer_rd_start,
  input wire logic xfer_done,
  input wire logic xfer_fail,
  input wire logic access_ok,
  input wire logic access_fail,
  output logic monitor_write_en,
  output logic ctrl_read_en,
  output logic slave_tx_en,
  // group commands
  input wire logic [1:0] run_cmd,
  input wire logic [1:0] tune_cmd,
  output plg_pkg::plg_run_e run_mode,
  output plg_pkg::plg_tune_e tune_mode,
  // status
  output logic comm_status,
  output logic comm_flag,
  output logic [3:0] recog_flags,
  output logic [4:0] module_count_out,
  output logic [7:0] transfer_result_flags,
  output logic [7:0] transfer_request_flags,
  output logic err_reg_access,
  output logic err_slave_timeout,
  output logic err_internal_timeout,
  output logic err_master_timeout
);
  // ******************************
  // input synchronisers
  // ******************************
  localparam int NSYNC = 16;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1_reg;
  logic [NSYNC-1:0] s2_reg;
  assign raw_in = {gather_done, sys_activity, addr_seq_ok, internal_err, master_link_err,
                   slave_mode, master_sending, unit_present, module_count};
  // no reset: the stages keep tracking the pins, so a high-idle pin shows no false fault
  always_ff @(posedge clk) begin
    s1_reg <= raw_in;
    s2_reg <= s1_reg;
  end
  logic g_done;
  logic act;
  logic seq_ok;
  logic int_err;
  logic m_err;
  logic is_slave;
  logic m_send;
  logic [3:0] present;
  logic [4:0] mcount;
  assign {g_done, act, seq_ok, int_err, m_err, is_slave, m_send, present, mcount} = s2_reg;

  // ******************************
  // one second enable
  // ******************************
  logic [31:0] div_reg;
  logic [31:0] div_next;
  logic sec_tick;
  always_comb begin
    div_next = div_reg + 32'h1;
    if (div_reg >= 32'(SEC_CYCLES - 1)) begin
      div_next = '0;
    end
  end
  assign sec_tick = (div_reg >= 32'(SEC_CYCLES - 1));
  always_ff @(posedge clk) begin
    if (srst) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  // ******************************
  // start delay and power-up sequence
  // ******************************
  function automatic logic [7:0] eff_delay(input logic [7:0] d);
    if (d == plg_pkg::START_DELAY_ZERO) begin
      eff_delay = 8'(plg_pkg::MIN_START_S);
    end else if (d < 8'(plg_pkg::START_DELAY_MIN_S)) begin
      eff_delay = 8'(plg_pkg::START_DELAY_MIN_S);
    end else begin
      eff_delay = d;
    end
  endfunction
  logic [7:0] delay_lim;
  logic delay_over;
  assign delay_lim = eff_delay(start_delay_s);
  plg_timer #(.WIDTH(8)) u_start (
    .clk(clk),
    .srst(srst),
    .sec_tick(sec_tick),
    .clear(1'b0),
    .limit(delay_lim),
    .expired(delay_over)
  );
  typedef enum logic [1:0] {plg_gather, plg_first_mon, plg_online} plg_up_e;
  plg_up_e up_reg;
  plg_up_e up_next;
  always_comb begin
    up_next = up_reg;
    case (up_reg)
      plg_gather: begin
        if (g_done && delay_over) begin
          up_next = plg_first_mon;
        end
      end
      plg_first_mon: begin
        up_next = plg_online;
      end
      plg_online: up_next = plg_online;
      default: up_next = plg_gather;
    endcase
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      up_reg <= plg_gather;
    end else begin
      up_reg <= up_next;
    end
  end
  assign comm_status = (up_reg == plg_online);
  assign ctrl_read_en = (up_reg != plg_gather);

  // ******************************
  // timeouts and error code
  // ******************************
  localparam logic [7:0] TO_LIM = 8'(plg_pkg::TIMEOUT_S + 1);
  logic sys_to;
  logic ok_long;
  logic acc_bad;
  // any failed access restarts the clean-access window
  assign acc_bad = access_fail || (xfer_fail && comm_status);
  // more than 3 s: expires on the fourth one-second tick after the clear, 3 to 4 s later
  plg_timer #(.WIDTH(8)) u_sys_to (
    .clk(clk),
    .srst(srst),
    .sec_tick(sec_tick),
    .clear(act),
    .limit(TO_LIM),
    .expired(sys_to)
  );
  plg_timer #(.WIDTH(8)) u_ok (
    .clk(clk),
    .srst(srst),
    .sec_tick(sec_tick),
    .clear(acc_bad || !access_ok),
    .limit(TO_LIM),
    .expired(ok_long)
  );
  logic [3:0] err_reg;
  logic [3:0] err_next;
  logic chain_big;
  assign chain_big = (chained_units > 2'(plg_pkg::SLAVE_CHAIN_MIN));
  always_comb begin
    err_next = err_reg;
    if (ok_long) begin
      err_next[0] = 1'b0;
    end
    // set wins over the clean-access clear
    if (acc_bad) begin
      err_next[0] = 1'b1;
    end
    if (chain_big && is_slave && sys_to) begin
      err_next[1] = 1'b1;
    end
    if (int_err || !seq_ok) begin
      err_next[2] = 1'b1;
    end
    if (m_err || (!is_slave && sys_to)) begin
      err_next[3] = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      err_reg <= '0;
    end else begin
      err_reg <= err_next;
    end
  end
  assign err_reg_access = err_reg[0];
  assign err_slave_timeout = err_reg[1];
  assign err_internal_timeout = err_reg[2];
  assign err_master_timeout = err_reg[3];
  logic comm_bad;
  assign comm_bad = |err_reg || sys_to;

  // ******************************
  // slave ready state
  // ******************************
  logic halt_reg;
  logic halt_next;
  always_comb begin
    halt_next = halt_reg;
    if (m_send) begin
      halt_next = 1'b0;
    end else if (is_slave && sys_to) begin
      halt_next = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      halt_reg <= 1'b0;
    end else begin
      halt_reg <= halt_next;
    end
  end
  assign slave_tx_en = !halt_reg;

  // ******************************
  // status registers
  // ******************************
  logic flag_reg;
  logic [3:0] recog_reg;
  logic [4:0] cnt_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      flag_reg <= 1'b0;
      recog_reg <= '0;
      cnt_reg <= plg_pkg::MODULE_COUNT_RESET;
    end else begin
      if (period_tick && comm_status && !comm_bad) begin
        flag_reg <= !flag_reg;
      end
      recog_reg <= present;
      cnt_reg <= mcount;
    end
  end
  assign comm_flag = flag_reg;
  assign recog_flags = recog_reg;
  assign module_count_out = cnt_reg;

  // ******************************
  // setting group transfer handshake
  // ******************************
  typedef enum logic [1:0] {plg_idle, plg_wr_busy, plg_rd_busy} plg_xf_e;
  plg_xf_e xf_reg;
  plg_xf_e xf_next;
  logic [1:0] req_reg;
  logic [1:0] req_next;
  logic [2:0] res_reg;
  logic [2:0] res_next;
  always_comb begin
    xf_next = xf_reg;
    req_next = req_reg;
    res_next = res_reg;
    xfer_wr_start = 1'b0;
    xfer_rd_start = 1'b0;
    // a new request clears its done bit; a completion in the same cycle wins
    if (req_wr_set) begin
      res_next[plg_pkg::RES_WR_BIT] = 1'b0;
    end
    if (req_rd_set) begin
      res_next[plg_pkg::RES_RD_BIT] = 1'b0;
    end
    case (xf_reg)
      plg_idle: begin
        // requests queue in req_reg until the engine is free
        if (comm_status && req_reg[plg_pkg::REQ_WR_BIT]) begin
          xf_next = plg_wr_busy;
          xfer_wr_start = 1'b1;
        end else if (comm_status && req_reg[plg_pkg::REQ_RD_BIT]) begin
          xf_next = plg_rd_busy;
          xfer_rd_start = 1'b1;
        end
      end
      plg_wr_busy: begin
        if (xfer_done) begin
          res_next[plg_pkg::RES_WR_BIT] = 1'b1;
          req_next[plg_pkg::REQ_WR_BIT] = 1'b0;
          xf_next = plg_idle;
        end else if (xfer_fail) begin
          res_next[plg_pkg::RES_ERR_BIT] = 1'b1;
          xf_next = plg_idle;
        end
      end
      plg_rd_busy: begin
        if (xfer_done) begin
          res_next[plg_pkg::RES_RD_BIT] = 1'b1;
          req_next[plg_pkg::REQ_RD_BIT] = 1'b0;
          xf_next = plg_idle;
        end else if (xfer_fail) begin
          res_next[plg_pkg::RES_ERR_BIT] = 1'b1;
          xf_next = plg_idle;
        end
      end
      default: xf_next = plg_idle;
    endcase
    // a failed request stays set and is retried; a fresh set wins over a clear
    if (req_wr_set) begin
      req_next[plg_pkg::REQ_WR_BIT] = 1'b1;
    end
    if (req_rd_set) begin
      req_next[plg_pkg::REQ_RD_BIT] = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      xf_reg <= plg_idle;
      req_reg <= plg_pkg::FLAGS_RESET[1:0];
      res_reg <= plg_pkg::FLAGS_RESET[2:0];
    end else begin
      xf_reg <= xf_next;
      req_reg <= req_next;
      res_reg <= res_next;
    end
  end
  assign transfer_result_flags = {5'h00, res_reg};
  assign transfer_request_flags = {6'h00, req_reg};
  assign monitor_write_en = (up_reg == plg_first_mon) ||
                            (comm_status && xf_reg == plg_idle);

  // ******************************
  // group commands
  // ******************************
  always_comb begin
    case (run_cmd)
      plg_pkg::CMD_CODE0: run_mode = plg_pkg::plg_run_all;
      plg_pkg::CMD_CODE1: run_mode = plg_pkg::plg_stop_all;
      default: run_mode = plg_pkg::plg_run_select;
    endcase
    case (tune_cmd)
      plg_pkg::CMD_CODE0: tune_mode = plg_pkg::plg_at_stop_all;
      plg_pkg::CMD_CODE1: tune_mode = plg_pkg::plg_at_exec_all;
      default: tune_mode = plg_pkg::plg_at_select;
    endcase
  end

  // ******************************
  // checks
  // ******************************
  a_result_done: assert property (@(posedge clk) disable iff (srst)
    xf_reg == plg_wr_busy && xfer_done && !req_wr_set |=>
    transfer_result_flags[1] && !transfer_request_flags[0])
    else $error("write completion not flagged");
  a_read_done: assert property (@(posedge clk) disable iff (srst)
    xf_reg == plg_rd_busy && xfer_done && !req_rd_set |=>
    transfer_result_flags[2] && !transfer_request_flags[1])
    else $error("read completion not flagged");
  a_fail_err: assert property (@(posedge clk) disable iff (srst)
    xf_reg != plg_idle && xfer_fail && !xfer_done |=> transfer_result_flags[0])
    else $error("failure not flagged");
  a_monitor_pause: assert property (@(posedge clk) disable iff (srst)
    xf_reg != plg_idle |-> !monitor_write_en)
    else $error("monitor writes during transfer");
  a_no_early_read: assert property (@(posedge clk) disable iff (srst)
    !delay_over && up_reg == plg_gather |=> !ctrl_read_en)
    else $error("controller read before delay");
  a_flag_frozen: assert property (@(posedge clk) disable iff (srst)
    comm_bad |=> $stable(comm_flag))
    else $error("comm flag toggled during fault");
  a_single_xfer: assert property (@(posedge clk) disable iff (srst)
    xf_reg != plg_idle |-> !xfer_wr_start && !xfer_rd_start)
    else $error("second transfer started");
  a_req_set: assert property (@(posedge clk) disable iff (srst)
    req_wr_set |=> transfer_request_flags[0])
    else $error("write request lost");
  a_result_pad: assert property (@(posedge clk) disable iff (srst)
    transfer_result_flags[7:3] == 5'h00 && transfer_request_flags[7:2] == 6'h00)
    else $error("unused result bits set");
endmodule // plg_gateway
`default_nettype wire

// >>> plg_pkg.sv
// package: constants for the ladderless gateway handshake block
package plg_pkg;
  // transfer result byte fields
  localparam int RES_ERR_BIT = 0;
  localparam int RES_WR_BIT = 1;
  localparam int RES_RD_BIT = 2;
  // transfer request byte fields
  localparam int REQ_WR_BIT = 0;
  localparam int REQ_RD_BIT = 1;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int TIMEOUT_S = 3;
  localparam int START_DELAY_DEFAULT_S = 10;
  localparam int START_DELAY_MIN_S = 8;
  localparam logic [7:0] START_DELAY_ZERO = 8'h00;
  localparam int MIN_START_S = 1;
  // command codes
  localparam logic [1:0] CMD_CODE0 = 2'h0;
  localparam logic [1:0] CMD_CODE1 = 2'h1;
  localparam logic [1:0] CMD_SELECT = 2'h2;
  localparam logic [4:0] MODULE_COUNT_RESET = 5'h00;
  localparam int SLAVE_CHAIN_MIN = 2;
  typedef enum logic [1:0] {
    plg_run_all,
    plg_stop_all,
    plg_run_select
  } plg_run_e;
  typedef enum logic [1:0] {
    plg_at_stop_all,
    plg_at_exec_all,
    plg_at_select
  } plg_tune_e;
endpackage : plg_pkg

// >>> plg_timer.sv
// module: seconds-based timeout counter driven by a one-second enable
`timescale 1ns/1ps
`default_nettype none
module plg_timer #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control
  input wire logic sec_tick,
  input wire logic clear,
  input wire logic [WIDTH-1:0] limit,
  // status
  output logic expired
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  always_comb begin
    count_next = count_reg;
    if (clear) begin
      count_next = '0;
    end else if (sec_tick && count_reg < limit) begin
      count_next = count_reg + WIDTH'(1);
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
  // counting stops at the limit so the flag stays up without wrapping
  assign expired = (count_reg >= limit);
endmodule // plg_timer
`default_nettype wire

// >>> plg_ctrl_model.sv
// controller side model: answers transfer starts with done or fail after a latency
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// transfer engine and controller registers
// ****************************************
module plg_ctrl_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // starts from the gateway
  input wire logic xfer_wr_start,
  input wire logic xfer_rd_start,
  // bench control: fail on purpose, answer latency
  input wire logic fail_next,
  input wire logic [3:0] lat,
  // answers
  output logic xfer_done,
  output logic xfer_fail
);
  logic busy_reg;
  logic [3:0] cnt_reg;
  // fail is sampled at completion so the bench can change it mid transfer
  always_ff @(posedge clk) begin
    xfer_done <= 1'b0;
    xfer_fail <= 1'b0;
    if (srst) begin
      busy_reg <= 1'b0;
      cnt_reg <= 4'h0;
    end else if (!busy_reg && (xfer_wr_start || xfer_rd_start)) begin
      busy_reg <= 1'b1;
      cnt_reg <= lat;
    end else if (busy_reg && cnt_reg == 4'h0) begin
      busy_reg <= 1'b0;
      xfer_fail <= fail_next;
      xfer_done <= !fail_next;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule // plg_ctrl_model
`default_nettype wire

// >>> plc_ladderless_handshake_tb_top.sv
// testbench top: drives the gateway and compares it with a small queue model
`timescale 1ns/1ps
`default_nettype none
module plc_ladderless_handshake_tb_top;
  // ****************************************
  // signals
  // ****************************************
  logic clk = 0, srst = 1, gather_done = 1, sys_activity = 1, addr_seq_ok = 1;
  logic internal_err = 0, master_link_err = 0, slave_mode = 0, master_sending = 0;
  logic req_wr_set = 0, req_rd_set = 0, period_tick = 0, access_ok = 1, access_fail = 0;
  logic fail_next = 0, f;
  logic [4:0] module_count = 5'h00;
  logic [3:0] unit_present = 4'h0, lat = 4'h4;
  logic [1:0] chained_units = 2'h0, run_cmd = 2'h2, tune_cmd = 2'h2;
  logic [7:0] start_delay_s = 8'h08;
  logic xfer_wr_start, xfer_rd_start, xfer_done, xfer_fail, monitor_write_en;
  logic ctrl_read_en, slave_tx_en, comm_status, comm_flag, err_reg_access;
  logic err_slave_timeout, err_internal_timeout, err_master_timeout;
  logic [3:0] recog_flags;
  logic [4:0] module_count_out;
  logic [7:0] transfer_result_flags, transfer_request_flags;
  plg_pkg::plg_run_e run_mode;
  plg_pkg::plg_tune_e tune_mode;
  int num_errors = 0, checked = 0, exp_req = 0, exp_res = 0, seed_v;
  int pend[$];
  always #5 clk = ~clk;
  // one second is ten cycles so the three second timeouts stay short
  plg_gateway #(.SEC_CYCLES(10), .START_DELAY_S(8'h0a)) DUT (.clk, .srst, .gather_done,
    .module_count, .unit_present, .sys_activity, .addr_seq_ok, .internal_err,
    .master_link_err, .slave_mode, .master_sending, .chained_units, .start_delay_s,
    .req_wr_set, .req_rd_set, .period_tick, .xfer_wr_start, .xfer_rd_start, .xfer_done,
    .xfer_fail, .access_ok, .access_fail, .monitor_write_en, .ctrl_read_en, .slave_tx_en,
    .run_cmd, .tune_cmd, .run_mode, .tune_mode, .comm_status, .comm_flag, .recog_flags,
    .module_count_out, .transfer_result_flags, .transfer_request_flags, .err_reg_access,
    .err_slave_timeout, .err_internal_timeout, .err_master_timeout);
  plg_ctrl_model ctrl (.clk, .srst, .xfer_wr_start, .xfer_rd_start, .fail_next, .lat,
    .xfer_done, .xfer_fail);
  // ****************************************
  // tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bytes();
    chk(transfer_request_flags, 8'(exp_req));
    chk(transfer_result_flags, 8'(exp_res));
  endtask
  // a request clears the matching done bit and waits in the queue behind a busy transfer
  task automatic req(input int k);
    pend.push_back(k);
    exp_req |= 1 << k;
    exp_res &= ~(2 << k);
    if (k == 0) req_wr_set = 1;
    else req_rd_set = 1;
    tick(1);
    req_wr_set = 0;
    req_rd_set = 0;
  endtask
  task automatic done();
    int k;
    k = pend.pop_front();
    exp_req &= ~(1 << k);
    exp_res |= 2 << k;
    chk_bytes();
  endtask
  task automatic wait_bit(input int sel, input logic val);
    logic b;
    for (int n = 0; n < 300; n++) begin
      b = (sel < 2) ? transfer_request_flags[sel] : (sel == 2) ? transfer_result_flags[0]
        : comm_status;
      if (b === val) break;
      tick(1);
    end
    chk(b, val);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ****************************************
  // watchdog
  // ****************************************
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    seed_v = $urandom(32'h779e8c78);
    tick(5);
    chk_bytes();
    chk({recog_flags, module_count_out, comm_status}, 0);
    srst = 0;
    tick(70);
    chk({comm_status, ctrl_read_en}, 0);
    wait_bit(3, 1);
    for (int i = 0; i < 3; i++) begin
      run_cmd = 2'(i);
      tune_cmd = 2'(i);
      module_count = 5'($urandom);
      unit_present = 4'($urandom);
      tick(4);
      chk(run_mode, i);
      chk(tune_mode, i);
      chk({recog_flags, module_count_out}, {unit_present, module_count});
      f = comm_flag;
      period_tick = 1;
      tick(1);
      period_tick = 0;
      tick(2);
      chk(comm_flag, !f);
    end
    run_cmd = 2'h3;
    tune_cmd = 2'h3;
    tick(1);
    chk(run_mode, 2);
    chk(tune_mode, 2);
    // write with a read raised behind it, then a second write
    lat = 4'($urandom_range(9, 4));
    req(0);
    chk_bytes();
    tick(1);
    chk(monitor_write_en, 0);
    req(1);
    wait_bit(0, 0);
    done();
    wait_bit(1, 0);
    done();
    req(0);
    chk_bytes();
    wait_bit(0, 0);
    done();
    // failing read, then a prompt retry
    fail_next = 1;
    lat = 4'h2;
    req(1);
    wait_bit(2, 1);
    fail_next = 0;
    lat = 4'h0;
    exp_res |= 1;
    tick(1);
    chk(err_reg_access, 1);
    wait_bit(1, 0);
    done();
    tick(10);
    chk(err_reg_access, 1);
    tick(60);
    chk(err_reg_access, 0);
    // link silence and internal faults
    sys_activity = 0;
    tick(20);
    chk(err_master_timeout, 0);
    tick(50);
    chk(err_master_timeout, 1);
    f = comm_flag;
    period_tick = 1;
    tick(1);
    period_tick = 0;
    tick(2);
    chk(comm_flag, f);
    internal_err = 1;
    tick(6);
    chk(err_internal_timeout, 1);
    // chained slave that loses the link, then hears the master again
    srst = 1;
    slave_mode = 1;
    chained_units = 2'h3;
    internal_err = 0;
    start_delay_s = 8'h00;
    tick(5);
    srst = 0;
    tick(70);
    chk(comm_status, 1);
    chk({err_slave_timeout, slave_tx_en}, 2'b10);
    master_sending = 1;
    tick(8);
    chk(slave_tx_en, 1);
    tally_and_finish();
  end
endmodule // plc_ladderless_handshake_tb_top
`default_nettype wire
